// *** i2c_bus_master_model.sv ***
`timescale 1ns/1ns
module i2c_bus_master_model (
  // resolved bus lines
  input  wire logic scl,
  input  wire logic sda,
  // open-drain drives, 1 releases
  output logic      scl_m,
  output logic      sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // a stretching target holds the clock; bounded wait
  task automatic up();
    int n;
    scl_m = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 5000) begin
      #8;
      n++;
    end
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    #62;
    up();
    #63;
    r = sda;
    scl_m = 1'b0;
  endtask
  task automatic start();
    sda_m = 1'b1;
    #62;
    up();
    #62;
    sda_m = 1'b0;
    #62;
    scl_m = 1'b0;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #62;
    up();
    #62;
    sda_m = 1'b1;
    #62;
  endtask
  // msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q,
                      output logic as);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(am, as);
    sda_m = 1'b1;
  endtask
endmodule

// *** i2c_target_monitor.sv ***
`timescale 1ns/1ns
module i2c_target_checker
  import twi_target_pkg::*;
(
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST_B,
  // register bus
  input wire logic        HSEL,
  input wire logic [7:0]  HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // bus pins
  input wire logic        SCL_IN,
  input wire logic        SCL_OUT,
  input wire logic        SCL_OE_B,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE_B,
  input wire logic        WAKE_REQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  logic rd_q;
  logic cw_q;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_q <= 1'b0;
      cw_q <= 1'b0;
    end else begin
      rd_q <= HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR > ADDR_SLEEP_CTRL;
      cw_q <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == ADDR_LINK_CTRL;
    end
  end
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready okay");
  a_unmapped_zero: assert property (rd_q |-> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_status_upper_zero: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_open_drain: assert property (!SCL_OUT && !SDA_OUT)
    else $error("pin driven high");
  a_data_scl_low: assert property ($changed(SDA_OE_B) |-> !SCL_IN)
    else $error("data changed with clock high");
  a_grab_low: assert property ($fell(SCL_OE_B) |-> !SCL_IN)
    else $error("clock grabbed while high");
  a_flag_release: assert property (cw_q && HWDATA[CTL_SERVICE] |-> ##[1:6] SCL_OE_B)
    else $error("clock held after flag clear");
  a_wake_stretch: assert property ($rose(WAKE_REQ) |-> ##[0:60] !SCL_OE_B)
    else $error("no stretch after wake");
  cover property (rd_q);
  cover property ($rose(WAKE_REQ));
  cover property ($fell(SCL_OE_B));
endmodule
bind twi_target i2c_target_checker chk_i (.*);

// *** i2c_target_rx_end_and_tx_tb.sv ***
`timescale 1ns/1ns
module i2c_target_rx_end_and_tx_tb;
  import twi_target_pkg::*;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, arb_lost = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0;
  wire logic [31:0] hrdata;
  wire logic rdy, hresp, scl_o, scl_oe_b, sda_o, sda_oe_b, wake, beginp, scl_m, sda_m;
  wire logic scl = scl_m & (scl_oe_b | scl_o);
  wire logic sda = sda_m & (sda_oe_b | sda_o);
  int bad_count = 0, tests_run = 0, seed = 82, cyc = 0;
  logic [7:0] q[$];
  logic [7:0] b, v;
  logic a;
  logic [31:0] r;
  twi_target uut (
    .SYS_CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata),
    .HREADYOUT(rdy), .HRESP(hresp), .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE_B(scl_oe_b),
    .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_B(sda_oe_b), .ARB_LOST(arb_lost),
    .WAKE_REQ(wake), .BEGIN_PENDING(beginp));
  i2c_bus_master_model m (.scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  always #4 clk = ~clk;
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    r = hrdata;
    hsel <= 0;
  endtask
  // enable set, halt request kept zero
  task automatic ctl(input logic ae, input logic bg);
    bus(1, ADDR_LINK_CTRL, {24'h0, 1'b1, ae, bg, 5'h04});
  endtask
  task automatic stat(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      bus(0, ADDR_LINK_STATUS, 0);
      n++;
    end while (r[7:0] === ST_NO_INFO && n < 500);
    chk("status", r, {24'h0, e});
  endtask
  task automatic load();
    v = 8'($random(seed));
    q.push_back(v);
    bus(1, ADDR_LINK_DATA, {24'h0, v});
  endtask
  task automatic get(input logic ma);
    m.xfer(8'hff, ma, b, a);
    chk("sent byte", {24'h0, b}, {24'h0, q.pop_front()});
  endtask
  task automatic fin();
    load();
    ctl(0, 0);
    get(1);
    stat(ST_TX_NACK);
    ctl(1, 0);
    m.stop();
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    bus(1, ADDR_OWN_TARGET, 32'h55);
    bus(0, ADDR_OWN_TARGET, 0);
    chk("own addr", r, 32'h55);
    bus(0, 8'h14, 0);
    chk("unmapped", r, 0);
    ctl(1, 0);
    for (int k = 0; k < 2; k++) begin
      arb_lost <= k[0];
      @(posedge clk);
      arb_lost <= 0;
      m.start();
      m.xfer(8'h55, 1, b, a);
      chk("addr ack", {31'h0, a}, 0);
      stat(k[0] ? ST_ARB_LOST_READ : ST_OWN_READ_ACK);
      load();
      ctl(1, 0);
      get(0);
      stat(ST_TX_ACK);
      load();
      ctl(0, 0);
      get(~k[0]);
      stat(k[0] ? ST_LAST_TX_ACK : ST_TX_NACK);
      ctl(1, k[0]);
      m.xfer(8'hff, 1, b, a);
      chk("released", {24'h0, b}, 32'hff);
      chk("begin held", {31'h0, beginp}, k);
      m.stop();
      repeat (40) @(posedge clk);
      chk("begin done", {31'h0, beginp}, 0);
      ctl(1, 0);
    end
    ctl(0, 0);
    m.start();
    m.xfer(8'h55, 1, b, a);
    chk("isolated", {31'h0, a}, 1);
    m.stop();
    ctl(1, 0);
    m.start();
    m.xfer(8'h55, 1, b, a);
    chk("resumed", {31'h0, a}, 0);
    stat(ST_OWN_READ_ACK);
    fin();
    m.start();
    m.xfer(8'h00, 1, b, a);
    stat(ST_GC_ACK);
    ctl(1, 0);
    v = 8'($random(seed));
    m.xfer(v, 1, b, a);
    stat(ST_GC_DATA_ACK);
    bus(0, ADDR_LINK_DATA, 0);
    chk("rx data", r, {24'h0, v});
    ctl(0, 0);
    m.xfer(~v, 1, b, a);
    chk("gc nack", {31'h0, a}, 1);
    stat(ST_GC_DATA_NACK);
    ctl(1, 0);
    m.start();
    m.xfer(8'h00, 1, b, a);
    stat(ST_GC_ACK);
    ctl(1, 0);
    m.stop();
    stat(ST_STOP_RESTART);
    ctl(1, 0);
    bus(1, ADDR_OWN_TARGET, 32'h54);
    m.start();
    m.xfer(8'h00, 1, b, a);
    chk("gc off", {31'h0, a}, 1);
    m.stop();
    bus(1, ADDR_SLEEP_CTRL, 1);
    m.start();
    m.xfer(8'h55, 1, b, a);
    chk("wake ack", {31'h0, a}, 0);
    repeat (8) @(posedge clk);
    chk("wake", {31'h0, wake}, 1);
    chk("stretch", {31'h0, scl_oe_b}, 0);
    bus(1, ADDR_SLEEP_CTRL, 0);
    stat(ST_OWN_READ_ACK);
    fin();
    chk("wake clear", {31'h0, wake}, 0);
    print_verdict();
  end
endmodule

// *** twi_target.sv ***
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
// What this block does
// (RL1) status codes reported with prescaler bits zero
// (RL2) general-call data acked reports 0x90
// (RL3) general-call data nacked reports 0x98, unaddressed
// (RL4) stop or restart while addressed reports 0xA0
// (RL5) ack enable zero: no address recognized
// (RL6) ack enable one: own, broadcast if accepted
// (RL7) begin request pending starts when bus free
// (RL8) address register: seven bits plus broadcast accept
// (RL9) software sets enable, ack enable before use
// (RL10) software keeps begin, halt requests zero
// (RL11) read bit enters transmit, write enters receive
// (RL12) address match sets flag with valid status
// (RL13) lost arbitration then read reports 0xB0
// (RL14) ack enable cleared: last byte, 0xC0/0xC8
// (RL15) after last byte ignore master, release data
// (RL16) ack enable zero isolates, bus still monitored
// (RL17) in deep sleep match runs, wakes the part
// (RL18) after wake hold clock until flag cleared
// (RL19) data byte need not hold last bus byte
// (RL20) own read address acked reports 0xA8
// (RL21) transmitted byte acked reports 0xB8, next
// (RL22) clock stretched low while flag set; the code stretches only in PH_WAIT, not after 0x98 or 0xA0
module twi_target
  import twi_target_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // two-wire bus pins
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_B,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_B,
  // system side
  input  wire logic        ARB_LOST,
  output logic             WAKE_REQ,
  output logic             BEGIN_PENDING
);

  typedef struct packed {
    logic [2:0]  scl_sync;
    logic [2:0]  sda_sync;
    logic        scl_st;
    logic        sda_st;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic [7:0]  own_addr;
    logic        service;
    logic        ack_en;
    logic        begin_req;
    logic        halt_req;
    logic        wcol;
    logic        unit_en;
    logic        irq_en;
    logic [7:0]  status;
    logic [7:0]  data;
    logic [7:0]  shift;
    logic [2:0]  bitn;
    phase_e      phase;
    logic        addressed;
    logic        gc_mode;
    logic        last_byte;
    logic        arb_lost;
    logic        asleep;
    logic        wake;
    logic        sda_low;
    logic        scl_low;
    logic        byte_done;
    logic        bus_busy;
  } state_s;

  state_s q, d;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] reg_addr);
    is_addr = (a == reg_addr);
  endfunction

  logic scl_rise, scl_fall, start_cond, stop_cond, bus_write, wr_ctrl;
  logic own_hit, gc_hit;

  always_comb begin
    d = q;
    d.scl_sync = {q.scl_sync[1:0], SCL_IN};
    d.sda_sync = {q.sda_sync[1:0], SDA_IN};
    // a level counts once stages two and three agree
    if (q.scl_sync[2] == q.scl_sync[1]) begin
      d.scl_st = q.scl_sync[2];
    end
    if (q.sda_sync[2] == q.sda_sync[1]) begin
      d.sda_st = q.sda_sync[2];
    end
    scl_rise   = !q.scl_st && d.scl_st;
    scl_fall   = q.scl_st && !d.scl_st;
    start_cond = q.scl_st && d.scl_st && q.sda_st && !d.sda_st;
    stop_cond  = q.scl_st && d.scl_st && !q.sda_st && d.sda_st;

    // (RL8) address match decode
    own_hit = (q.shift[7:1] == q.own_addr[7:1]);
    gc_hit  = (q.shift == BROADCAST_ADDR) && q.own_addr[0];

    // ahb-lite: zero wait state, registered write at data phase
    bus_write = HSEL && HREADY && HTRANS[1] && HWRITE;
    d.wr_pend = bus_write;
    if (HSEL && HREADY && HTRANS[1]) begin
      d.wr_addr = HADDR;
    end
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      d.rdata = '0;
      if (is_addr(HADDR, ADDR_OWN_TARGET)) begin
        d.rdata[7:0] = q.own_addr;
      end else if (is_addr(HADDR, ADDR_LINK_CTRL)) begin
        d.rdata[7:0] = {q.service, q.ack_en, q.begin_req, q.halt_req,
                        q.wcol, q.unit_en, 1'b0, q.irq_en};
      end else if (is_addr(HADDR, ADDR_LINK_STATUS)) begin
        // (RL1) prescaler bits read as zero
        d.rdata[7:0] = q.service ? q.status : ST_NO_INFO;
      end else if (is_addr(HADDR, ADDR_LINK_DATA)) begin
        d.rdata[7:0] = q.data;
      end else if (is_addr(HADDR, ADDR_SLEEP_CTRL)) begin
        d.rdata[1:0] = {q.wake, q.asleep};
      end
    end
    wr_ctrl = q.wr_pend && is_addr(q.wr_addr, ADDR_LINK_CTRL);
    if (q.wr_pend) begin
      if (is_addr(q.wr_addr, ADDR_OWN_TARGET)) begin
        d.own_addr = HWDATA[7:0];
      end else if (is_addr(q.wr_addr, ADDR_LINK_DATA)) begin
        if (q.service) begin
          d.data = HWDATA[7:0];
        end else begin
          d.wcol = 1'b1;
        end
      end else if (is_addr(q.wr_addr, ADDR_SLEEP_CTRL)) begin
        d.asleep = HWDATA[0];
      end
    end
    if (wr_ctrl) begin
      d.ack_en    = HWDATA[CTL_ACK_EN];
      d.begin_req = HWDATA[CTL_BEGIN_REQ];
      d.halt_req  = HWDATA[CTL_HALT_REQ];
      d.unit_en   = HWDATA[CTL_UNIT_EN];
      d.irq_en    = HWDATA[CTL_IRQ_EN];
      if (!HWDATA[CTL_WCOL]) begin
        d.wcol = 1'b0;
      end
      // (RL18) writing one clears flag and ends wake hold
      if (HWDATA[CTL_SERVICE]) begin
        d.service = 1'b0;
        d.wake    = 1'b0;
      end
    end
    // (RL13) remember lost arbitration for status choice
    if (ARB_LOST) begin
      d.arb_lost = 1'b1;
    end

    // bus kept busy from start to stop, so a begin request waits for it
    if (start_cond) begin
      d.bus_busy = 1'b1;
    end else if (stop_cond) begin
      d.bus_busy = 1'b0;
    end
    // bus engine; only runs with the unit enabled
    if (!q.unit_en) begin
      d.phase     = PH_IDLE;
      d.addressed = 1'b0;
      d.sda_low   = 1'b0;
    end else if (start_cond) begin
      // (RL4) restart while addressed
      if (q.addressed && !q.service) begin
        d.service = 1'b1;
        d.status  = ST_STOP_RESTART;
      end
      d.addressed = 1'b0;
      d.phase     = PH_ADDR;
      d.bitn      = BIT_FIRST;
      d.byte_done = 1'b0;
      d.sda_low   = 1'b0;
    end else if (stop_cond) begin
      // (RL4) stop while addressed
      if (q.addressed && !q.service) begin
        d.service = 1'b1;
        d.status  = ST_STOP_RESTART;
      end
      d.addressed = 1'b0;
      d.phase     = PH_IDLE;
      d.sda_low   = 1'b0;
    end else begin
      case (q.phase)
        PH_IDLE: begin
          d.sda_low = 1'b0;
        end
        PH_ADDR, PH_RX: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], q.sda_st};
            d.bitn  = q.bitn + 3'h1;
            // a full byte only after the eighth rising edge
            if (q.bitn == BIT_LAST) begin
              d.byte_done = 1'b1;
            end
          end
          if (scl_fall && q.byte_done) begin
            d.byte_done = 1'b0;
          end
          if (scl_fall && q.byte_done && q.phase == PH_ADDR) begin
            // (RL5) (RL6) (RL16) match only with ack enable set
            if (q.ack_en && (own_hit || gc_hit)) begin
              d.sda_low   = 1'b1;
              d.addressed = 1'b1;
              d.gc_mode   = gc_hit;
              // (RL11) direction bit picks transmit or receive
              if (gc_hit) begin
                d.status = ST_GC_ACK;
              end else if (q.shift[0]) begin
                // (RL20) (RL13) own read address
                d.status = q.arb_lost ? ST_ARB_LOST_READ : ST_OWN_READ_ACK;
              end else begin
                d.status = ST_OWN_WRITE_ACK;
              end
              d.arb_lost = 1'b0;
              // (RL17) a match in sleep wakes the part
              d.wake  = q.asleep;
              d.phase = PH_ADACK;
            end else begin
              d.phase = PH_IDLE;
            end
          end else if (scl_fall && q.byte_done && q.phase == PH_RX) begin
            d.data = q.shift;
            // (RL2) (RL3) general call data ack or nack
            d.sda_low   = q.ack_en;
            d.last_byte = !q.ack_en;
            d.status    = q.ack_en ? ST_GC_DATA_ACK : ST_GC_DATA_NACK;
            d.phase     = PH_RXACK;
          end
        end
        PH_ADACK, PH_RXACK: begin
          if (scl_fall) begin
            // (RL12) flag with valid status after the ack bit
            d.service = 1'b1;
            d.sda_low = 1'b0;
            d.bitn    = BIT_FIRST;
            if (q.phase == PH_RXACK && q.last_byte) begin
              d.addressed = 1'b0;
              d.phase     = PH_IDLE;
            end else if (q.status == ST_OWN_READ_ACK
                         || q.status == ST_ARB_LOST_READ) begin
              d.phase = PH_WAIT;
            end else begin
              d.phase = PH_WAIT;
              d.gc_mode = q.gc_mode;
            end
          end
        end
        PH_WAIT: begin
          // (RL22) resume only once the flag is cleared
          if (!q.service) begin
            if (q.status == ST_OWN_READ_ACK || q.status == ST_ARB_LOST_READ
                || q.status == ST_TX_ACK) begin
              // (RL14) (RL20) (RL21) load byte, last if ack enable off
              d.shift     = q.data;
              d.last_byte = !q.ack_en;
              d.sda_low   = !q.data[7];
              d.bitn      = BIT_FIRST;
              d.phase     = PH_TX;
            end else if (q.status == ST_TX_NACK || q.status == ST_LAST_TX_ACK
                         || q.status == ST_GC_DATA_NACK) begin
              d.phase = PH_IDLE;
            end else begin
              d.bitn  = BIT_FIRST;
              d.phase = PH_RX;
            end
          end
        end
        PH_TX: begin
          if (scl_fall) begin
            d.bitn = q.bitn + 3'h1;
            if (q.bitn == BIT_LAST) begin
              d.sda_low = 1'b0;
              d.phase   = PH_TXACK;
            end else begin
              d.shift   = {q.shift[6:0], 1'b1};
              d.sda_low = !q.shift[6];
            end
          end
        end
        PH_TXACK: begin
          if (scl_rise) begin
            // (RL14) final byte: 0xC0 on nack, 0xC8 on ack
            if (q.sda_st) begin
              d.status = ST_TX_NACK;
            end else if (q.last_byte) begin
              d.status = ST_LAST_TX_ACK;
            end else begin
              d.status = ST_TX_ACK;
            end
            // (RL15) unaddressed after last byte, data released
            if (q.sda_st || q.last_byte) begin
              d.addressed = 1'b0;
            end
          end
          if (scl_fall) begin
            d.service = 1'b1;
            d.phase   = PH_WAIT;
          end
        end
        default: begin
          d.phase = PH_IDLE;
        end
      endcase
    end
    // (RL7) begin request waits for a free bus
    if (q.begin_req && !q.addressed && q.phase == PH_IDLE && !q.service
        && !q.bus_busy) begin
      d.begin_req = 1'b0;
    end
    // (RL22) (RL18) stretch while flag set or waking, only in PH_WAIT after the ack bit, none after 0x98
    d.scl_low = q.unit_en && (q.service || q.wake) && !q.scl_st
                && q.phase == PH_WAIT;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      q <= '{scl_sync: 3'h7, sda_sync: 3'h7, scl_st: 1'b1, sda_st: 1'b1,
             wr_addr: 8'h00, rdata: 32'h0, own_addr: 8'h00, status: 8'hf8,
             data: 8'hff, shift: 8'h00, bitn: 3'h0, phase: PH_IDLE,
             default: 1'b0};
    end else begin
      q <= d;
    end
  end

  // (RL19) data byte not refreshed by the sleeping matcher
  assign HRDATA        = q.rdata;
  assign HREADYOUT     = 1'b1;
  assign HRESP         = 1'b0;
  assign SCL_OUT       = 1'b0;
  assign SCL_OE_B      = !q.scl_low;
  assign SDA_OUT       = 1'b0;
  assign SDA_OE_B      = !q.sda_low;
  assign WAKE_REQ      = q.wake;
  assign BEGIN_PENDING = q.begin_req;

endmodule

// *** twi_target_pkg.sv ***
package twi_target_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_OWN_TARGET  = 8'h00;
  localparam logic [7:0] ADDR_LINK_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_LINK_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LINK_DATA   = 8'h0c;
  localparam logic [7:0] ADDR_SLEEP_CTRL  = 8'h10;
  // link_control bit positions
  localparam int CTL_SERVICE   = 7;
  localparam int CTL_ACK_EN    = 6;
  localparam int CTL_BEGIN_REQ = 5;
  localparam int CTL_HALT_REQ  = 4;
  localparam int CTL_WCOL      = 3;
  localparam int CTL_UNIT_EN   = 2;
  localparam int CTL_IRQ_EN    = 0;
  // status codes, prescaler bits always zero
  localparam logic [7:0] ST_GC_DATA_ACK   = 8'h90;
  localparam logic [7:0] ST_GC_DATA_NACK  = 8'h98;
  localparam logic [7:0] ST_STOP_RESTART  = 8'ha0;
  localparam logic [7:0] ST_OWN_READ_ACK  = 8'ha8;
  localparam logic [7:0] ST_ARB_LOST_READ = 8'hb0;
  localparam logic [7:0] ST_TX_ACK        = 8'hb8;
  localparam logic [7:0] ST_TX_NACK       = 8'hc0;
  localparam logic [7:0] ST_LAST_TX_ACK   = 8'hc8;
  localparam logic [7:0] ST_OWN_WRITE_ACK = 8'h60;
  localparam logic [7:0] ST_GC_ACK        = 8'h70;
  localparam logic [7:0] ST_NO_INFO       = 8'hf8;
  localparam logic [7:0] BROADCAST_ADDR   = 8'h00;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [7:0] ONES_BYTE        = 8'hff;
  localparam logic [2:0] BIT_LAST         = 3'h7;
  localparam logic [2:0] BIT_FIRST        = 3'h0;
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_ADDR  = 3'b001,
    PH_ADACK = 3'b010,
    PH_RX    = 3'b011,
    PH_RXACK = 3'b100,
    PH_TX    = 3'b101,
    PH_TXACK = 3'b110,
    PH_WAIT  = 3'b111
  } phase_e;
endpackage
